/* design/acc_map.svh */
// Purpose: Register offsets, field positions and timing counts of the
//          converter control block.
// Assumes: 8-bit special function register bus, 8-bit addresses.
// Notes:   Definitions only.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ACC_OFF_CLK_DIV   8'hF2
`define ACC_OFF_CONTROL   8'hF3
`define ACC_OFF_RES_LOW   8'hF4
`define ACC_OFF_RES_HIGH  8'hF5
`define ACC_OFF_PIN_CFG   8'hF6

// ----------------------------------------------------------------------
// Control and divider register fields
// ----------------------------------------------------------------------
`define ACC_BIT_PSEUDO_IDLE_SELECT    6
`define ACC_BIT_ENABLE    5
`define ACC_BIT_DONE      4
`define ACC_BIT_START     3
`define ACC_CH_HI         2
`define ACC_CH_LO         0
`define ACC_DIV_HI        4
`define ACC_DIV_LO        0

// ----------------------------------------------------------------------
// Reset values and divider figures
// ----------------------------------------------------------------------
`define ACC_RST_BYTE      8'h00
`define ACC_RST_DIV       5'h00
`define ACC_RST_RES       10'h000
`define ACC_ZERO_DIV_X1   8'h80
`define ACC_ZERO_DIV_X2   8'h40
`define ACC_MUL_X1        3'h4
`define ACC_MUL_X2        3'h2
`define ACC_ONE8          8'h01
`define ACC_ZERO8         8'h00
// Sample-and-hold plus ten bit steps, counted in converter clocks
`define ACC_CONV_CLOCKS   4'hB
`define ACC_ONE4          4'h1
`define ACC_ZERO4         4'h0

`endif

/* design/acc_pkg.sv */
// Purpose: Types shared by the converter control block.
// Assumes: Offsets and counts live in acc_map.svh.
// Notes:   Holds the sequencer state type only.
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_CONVERT,
    ACC_FINISH
  } acc_state_e;
endpackage

/* design/acc_clk_div.sv */
// Purpose: Converter clock enable from the core clock and the divisor.
// Assumes: One clock; output is a one-cycle enable pulse.
// Notes:   Ratio 4*div or 128 in standard mode, 2*div or 64 in double.
`timescale 1ns/1ps
`include "acc_map.svh"

module acc_clk_div (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic       double_speed_clock_mode,
  input  wire logic [4:0] clock_divisor,
  output logic            tick
);

  logic [7:0] count;
  logic [7:0] ratio;
  logic [7:0] mult;
  logic [7:0] next_count;
  logic       wrap;

  // ----------------------------------------------------------------------
  // Ratio selection
  // ----------------------------------------------------------------------
  // Divisor multiplier: 2 in double mode, 4 in standard mode
  assign mult  = double_speed_clock_mode ? 8'(`ACC_MUL_X2)
                                         : 8'(`ACC_MUL_X1);
  assign ratio = (clock_divisor == `ACC_RST_DIV)
               ? (double_speed_clock_mode ? `ACC_ZERO_DIV_X2
                                          : `ACC_ZERO_DIV_X1)
               : 8'(mult * 8'(clock_divisor));
  assign wrap       = (count >= ratio - `ACC_ONE8);
  assign next_count = wrap ? `ACC_ZERO8 : count + `ACC_ONE8;

  // Counter held at zero while stopped so every conversion starts aligned
  always_ff @(posedge mclk) begin
    if (sys_rst || !run) begin
      count <= `ACC_ZERO8;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= wrap;
    end
  end

endmodule // acc_clk_div

/* design/acc_conv_ctrl.sv */
// Purpose: Register file and sequencer of a 10-bit converter.
// Assumes: Byte-wide register port at documented offsets; analog core
//          returns a 10-bit sample after eleven converter clocks.
// Notes:   Reserved bits read as zero.
`timescale 1ns/1ps
`include "acc_map.svh"

module acc_conv_ctrl (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       double_speed_clock_mode,
  input  wire logic       converter_irq_enable,
  input  wire logic [9:0] converter_result,
  output logic      [2:0] converter_input,
  output logic      [7:0] pin_analog_select,
  output logic            converter_powered,
  output logic            sample_hold,
  output logic            core_pseudo_idle,
  output logic            conversion_irq
);

  logic [4:0]        clock_divisor;
  logic              pseudo_idle_select;
  logic              converter_enable;
  logic              conversion_done_flag;
  logic              conversion_start_busy;
  logic [2:0]        input_channel_select;
  logic [9:0]        result;
  logic [3:0]        step;
  acc_pkg::acc_state_e state;
  acc_pkg::acc_state_e next_state;
  logic              tick;
  logic              irq_prev;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire sel_div  = (reg_addr == `ACC_OFF_CLK_DIV);
  wire sel_ctl  = (reg_addr == `ACC_OFF_CONTROL);
  wire sel_lo   = (reg_addr == `ACC_OFF_RES_LOW);
  wire sel_hi   = (reg_addr == `ACC_OFF_RES_HIGH);
  wire sel_cfg  = (reg_addr == `ACC_OFF_PIN_CFG);
  wire wr_ctl   = reg_wr && sel_ctl;
  wire start_wr = wr_ctl && reg_wdata[`ACC_BIT_START];
  // Enable as it stands after this edge, so a start that also sets the
  // enable bit runs at once and a write that clears it aborts at once
  wire run_en   = wr_ctl ? reg_wdata[`ACC_BIT_ENABLE] : converter_enable;
  wire chan_ok  = pin_analog_select[reg_wdata[`ACC_CH_HI:`ACC_CH_LO]];
  wire start_ok = start_wr && reg_wdata[`ACC_BIT_ENABLE] && chan_ok
               && (state == acc_pkg::ACC_IDLE);
  wire done_ev  = (state == acc_pkg::ACC_FINISH);
  wire [7:0] ctl_view = {1'b0, pseudo_idle_select, converter_enable,
                         conversion_done_flag, conversion_start_busy,
                         input_channel_select};
  wire [7:0] rd_mux =
    sel_div ? {3'h0, clock_divisor} :
    sel_ctl ? ctl_view :
    sel_lo  ? {6'h00, result[1:0]} :
    sel_hi  ? result[9:2] :
    sel_cfg ? pin_analog_select : `ACC_RST_BYTE;

  // ----------------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------------
  acc_clk_div u_div (
    .mclk                    (mclk),
    .sys_rst                 (sys_rst),
    .run                     (state == acc_pkg::ACC_CONVERT),
    .double_speed_clock_mode (double_speed_clock_mode),
    .clock_divisor           (clock_divisor),
    .tick                    (tick)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      acc_pkg::ACC_IDLE:    if (start_ok) next_state = acc_pkg::ACC_CONVERT;
      acc_pkg::ACC_CONVERT: if (tick && step == `ACC_CONV_CLOCKS - `ACC_ONE4)
                              next_state = acc_pkg::ACC_FINISH;
      acc_pkg::ACC_FINISH:  next_state = acc_pkg::ACC_IDLE;
      default:              next_state = acc_pkg::ACC_IDLE;
    endcase
  end

  // State and step counter; disabling the converter aborts a conversion
  always_ff @(posedge mclk) begin
    if (sys_rst || !run_en) begin
      state <= acc_pkg::ACC_IDLE;
      step  <= `ACC_ZERO4;
    end else begin
      state <= next_state;
      if (state != acc_pkg::ACC_CONVERT)
        step <= `ACC_ZERO4;
      else if (tick)
        step <= step + `ACC_ONE4;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Divisor field and analog pin configuration
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clock_divisor     <= `ACC_RST_DIV;
      pin_analog_select <= `ACC_RST_BYTE;
    end else begin
      if (reg_wr && sel_div)
        clock_divisor <= reg_wdata[`ACC_DIV_HI:`ACC_DIV_LO];
      if (reg_wr && sel_cfg)
        pin_analog_select <= reg_wdata;
    end
  end

  // Control fields; hardware set of the done flag beats a software clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pseudo_idle_select    <= 1'b0;
      converter_enable      <= 1'b0;
      input_channel_select  <= 3'h0;
      conversion_done_flag  <= 1'b0;
      conversion_start_busy <= 1'b0;
    end else begin
      if (wr_ctl) begin
        pseudo_idle_select   <= reg_wdata[`ACC_BIT_PSEUDO_IDLE_SELECT];
        converter_enable     <= reg_wdata[`ACC_BIT_ENABLE];
        input_channel_select <= reg_wdata[`ACC_CH_HI:`ACC_CH_LO];
      end
      if (done_ev)
        conversion_done_flag <= 1'b1;
      else if (wr_ctl && !reg_wdata[`ACC_BIT_DONE])
        conversion_done_flag <= 1'b0;
      if (start_ok)
        conversion_start_busy <= 1'b1;
      else if (done_ev || !run_en)
        conversion_start_busy <= 1'b0;
    end
  end

  // Result capture and registered outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      result            <= `ACC_RST_RES;
      reg_rdata         <= `ACC_RST_BYTE;
      converter_input   <= 3'h0;
      converter_powered <= 1'b0;
      sample_hold       <= 1'b0;
      core_pseudo_idle  <= 1'b0;
      conversion_irq    <= 1'b0;
      irq_prev          <= 1'b0;
    end else begin
      if (done_ev)
        result <= converter_result;
      reg_rdata <= reg_rd ? rd_mux : `ACC_RST_BYTE;
      converter_input   <= input_channel_select;
      converter_powered <= converter_enable;
      sample_hold       <= (state == acc_pkg::ACC_CONVERT)
                        && (step == `ACC_ZERO4);
      core_pseudo_idle  <= pseudo_idle_select && conversion_start_busy;
      conversion_irq    <= conversion_done_flag && converter_irq_enable;
      irq_prev          <= conversion_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_start;
    start_ok;
  endsequence
  sequence s_busy_hold;
    conversion_start_busy ##1 (conversion_start_busy || !converter_enable);
  endsequence

  a_start_sets_busy: assert property (@(posedge mclk) disable iff (sys_rst)
    s_start |=> s_busy_hold) else $error("busy not held after start");
  a_done_sets_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    done_ev |=> conversion_done_flag && !conversion_start_busy)
    else $error("done did not set flag");
  a_flag_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    conversion_done_flag && !wr_ctl |=> conversion_done_flag)
    else $error("done flag dropped");
  a_irq_follows: assert property (@(posedge mclk) disable iff (sys_rst)
    conversion_irq |-> $past(conversion_done_flag && converter_irq_enable))
    else $error("request without flag");
  a_standby_no_go: assert property (@(posedge mclk) disable iff (sys_rst)
    start_wr && !reg_wdata[`ACC_BIT_ENABLE] |=> state == acc_pkg::ACC_IDLE)
    else $error("start in standby");
  a_bad_channel: assert property (@(posedge mclk) disable iff (sys_rst)
    start_wr && !chan_ok && state == acc_pkg::ACC_IDLE
      |=> !conversion_start_busy) else $error("start on digital pin");
  a_result_high: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_rd && sel_hi |=> reg_rdata == $past(result[9:2]))
    else $error("high byte wrong");
  a_result_low: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_rd && sel_lo |=> reg_rdata == {6'h00, $past(result[1:0])})
    else $error("low byte wrong");
  a_div_upper: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_rd && sel_div |=> reg_rdata[7:5] == 3'h0)
    else $error("divider upper bits set");
  a_pseudo_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    core_pseudo_idle |-> $past(pseudo_idle_select))
    else $error("idle without select");
  a_standby_pwr: assert property (@(posedge mclk) disable iff (sys_rst)
    !converter_enable |=> !converter_powered)
    else $error("powered in standby");

endmodule // acc_conv_ctrl

/* verif/tb.sv */
// Purpose: Self-checking bench for the converter control block.
// Assumes: Register strobes are one-cycle pulses; read data is valid in
//          the cycle after the read strobe.
// Notes:   Inputs change 1 ns after the rising edge of mclk.
`timescale 1ns/1ps
`include "acc_map.svh"

module tb;
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       double_speed_clock_mode = 1'b0;
  logic       converter_irq_enable = 1'b0;
  logic [9:0] converter_result = 10'h000;
  logic [2:0] converter_input;
  logic [7:0] pin_analog_select;
  logic       converter_powered;
  logic       sample_hold;
  logic       core_pseudo_idle;
  logic       conversion_irq;
  int         miscompares = 0;
  int         n_checks = 0;

  acc_conv_ctrl dut (
    .mclk                    (mclk),
    .sys_rst                 (sys_rst),
    .reg_addr                (reg_addr),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_wdata               (reg_wdata),
    .reg_rdata               (reg_rdata),
    .double_speed_clock_mode (double_speed_clock_mode),
    .converter_irq_enable    (converter_irq_enable),
    .converter_result        (converter_result),
    .converter_input         (converter_input),
    .pin_analog_select       (pin_analog_select),
    .converter_powered       (converter_powered),
    .sample_hold             (sample_hold),
    .core_pseudo_idle        (core_pseudo_idle),
    .conversion_irq          (conversion_irq)
  );

  // ------------------------------------------------------------------
  // Clock, verdict and shared bus tasks
  // ------------------------------------------------------------------
  // 20 MHz core clock
  always #25 mclk = ~mclk;

  task automatic summarize;
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe is held across exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(posedge mclk) #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) #1;
    reg_addr = a; reg_rd = 1'b1;
    @(posedge mclk) #1;
    reg_rd = 1'b0;
    chk({2'b00, reg_rdata}, {2'b00, exp});
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Every register, the pin select and the request clear after reset; unmapped reads 00
  task automatic t_reset;
    for (int a = 8'hF2; a <= 8'hF7; a++) rd(8'(a), 8'h00);
    chk({2'b0, pin_analog_select}, 10'h000);
    chk({9'b0, conversion_irq}, 10'h000);
  endtask

  // Pin marks, start refused on unconfigured pin and in standby
  task automatic t_refuse;
    wr(`ACC_OFF_PIN_CFG, 8'hA5);
    chk({2'b0, pin_analog_select}, 10'h0A5);
    rd(`ACC_OFF_PIN_CFG, 8'hA5);
    wr(`ACC_OFF_CONTROL, 8'h29);
    repeat (3) @(posedge mclk);
    rd(`ACC_OFF_CONTROL, 8'h21);
    chk({9'b0, sample_hold}, 10'h000);
    wr(`ACC_OFF_CONTROL, 8'h0D);
    rd(`ACC_OFF_CONTROL, 8'h05);
    chk({9'b0, converter_powered}, 10'h000);
  endtask

  // One conversion: ratio, busy, channel, pseudo-idle, result, done
  task automatic t_conv(input logic x2, input logic [4:0] dv,
                        input logic [2:0] ch, input logic ps,
                        input logic [9:0] res);
    int r;
    int cnt;
    logic sh;
    logic [7:0] cw;
    r = x2 ? ((dv != 0) ? 2 * dv : 64) : ((dv != 0) ? 4 * dv : 128);
    double_speed_clock_mode = x2;
    converter_irq_enable = 1'b1;
    converter_result = res;
    wr(`ACC_OFF_PIN_CFG, 8'hFF);
    wr(`ACC_OFF_CLK_DIV, {3'b000, dv});
    rd(`ACC_OFF_CLK_DIV, {3'b000, dv});
    // Mask channel field, merge channel, then start
    cw = (8'h27 & 8'hF8) | {5'h00, ch};
    cw = cw | (ps ? 8'h48 : 8'h08);
    wr(`ACC_OFF_CONTROL, cw);
    rd(`ACC_OFF_CONTROL, {1'b0, ps, 3'b101, ch});
    chk({7'b0, converter_input}, {7'b0, ch});
    chk({9'b0, core_pseudo_idle}, {9'b0, ps});
    chk({9'b0, converter_powered}, 10'h001);
    cnt = 2;
    sh = 1'b0;
    while (conversion_irq !== 1'b1 && cnt < 2000) begin
      @(posedge mclk) #1;
      cnt++;
      sh = sh | (sample_hold === 1'b1);
    end
    // Eleven converter clocks, flag two cycles later, request one more
    n_checks++;
    if (cnt != 11 * r + 3) begin
      miscompares++;
      $display("Error at %0t: conversion took %0d cycles", $time, cnt);
    end
    chk({9'b0, sh}, 10'h001);
    chk({9'b0, core_pseudo_idle}, 10'h000);
    rd(`ACC_OFF_RES_HIGH, res[9:2]);
    rd(`ACC_OFF_RES_LOW, {6'b000000, res[1:0]});
    rd(`ACC_OFF_CONTROL, {1'b0, ps, 3'b110, ch});
    // Done flag is sticky; the request follows the enable level
    converter_irq_enable = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk({9'b0, conversion_irq}, 10'h000);
    converter_irq_enable = 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk({9'b0, conversion_irq}, 10'h001);
    wr(`ACC_OFF_CONTROL, {3'b001, 2'b00, ch});
    @(posedge mclk) #1;
    chk({9'b0, conversion_irq}, 10'h000);
    rd(`ACC_OFF_CONTROL, {3'b001, 2'b00, ch});
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    #1 sys_rst = 1'b0;
    t_reset();
    t_refuse();
    t_conv(1'b0, 5'h00, 3'h0, 1'b1, 10'h2A5);
    t_conv(1'b0, 5'h03, 3'h3, 1'b0, 10'h15A);
    t_conv(1'b1, 5'h00, 3'h5, 1'b1, 10'h3FF);
    t_conv(1'b1, 5'h1F, 3'h7, 1'b0, 10'h001);
    summarize();
  end

  // Longest run is about three thousand cycles
  initial begin
    #(20000 * 50);
    miscompares++;
    summarize();
  end
endmodule // tb
